/* File: rtl/wdt_pkg.sv */
// Shared constants and types of the 8-bit watchdog timer.
// Assumes a 32-bit APB slave port with one register per aligned word.
package wdt_pkg;

	// Bus and datapath widths
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned CNT_W    = 8;
	localparam int unsigned SEL_W    = 4;
	localparam int unsigned PRE_W    = 13;
	localparam int unsigned TAP_BASE = 6;
	localparam int unsigned NUM_TAPS = 8;
	localparam int unsigned TAP_W    = 3;
	localparam int unsigned PULSE_W  = 9;
	localparam int unsigned IRQ_W    = 3;

	typedef logic [ADDR_W-1:0] wdt_addr_t;

	// Register byte offsets
	localparam wdt_addr_t OFF_CTRL     = 12'h000;
	localparam wdt_addr_t OFF_COUNT    = 12'h004;
	localparam wdt_addr_t OFF_CLKSEL   = 12'h008;
	localparam wdt_addr_t OFF_IRQ_STAT = 12'h00C;
	localparam wdt_addr_t OFF_IRQ_MASK = 12'h010;

	// Counter values
	localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
	localparam logic [CNT_W-1:0] COUNT_MAX = 8'hFF;
	localparam logic [CNT_W-1:0] COUNT_ONE = 8'h01;

	// Clock select field
	localparam logic [SEL_W-1:0] CLKSEL_RST  = 4'hF;
	localparam logic [SEL_W-1:0] CLKSEL_RSVD = 4'hF;
	localparam int unsigned      CLKSEL_PRE  = 3;

	// Control/status bit positions
	localparam int unsigned CS_CWEN_GUARD = 7;
	localparam int unsigned CS_CWEN       = 6;
	localparam int unsigned CS_CTWE_GUARD = 5;
	localparam int unsigned CS_CTWE       = 4;
	localparam int unsigned CS_RUN_GUARD  = 3;
	localparam int unsigned CS_RUN        = 2;
	localparam int unsigned CS_FLAG_GUARD = 1;
	localparam int unsigned CS_FLAG       = 0;

	// Reset pulse length in oscillator cycles; the count's last index is one less
	localparam logic [PULSE_W-1:0] PULSE_OSC_CYC = 9'h100;
	localparam logic [PULSE_W-1:0] PULSE_ZERO    = 9'h000;
	localparam logic [PULSE_W-1:0] PULSE_ONE     = 9'h001;

	// Interrupt status bit positions
	localparam int unsigned IRQ_OVF       = 0;
	localparam int unsigned IRQ_PULSE_END = 1;
	localparam int unsigned IRQ_PIN_RST   = 2;
	localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;

	typedef struct packed {
		logic counter_wen;
		logic control_wen;
		logic run;
		logic reset_flag;
	} wdt_ctrl_s;

	localparam wdt_ctrl_s CTRL_RST = '{counter_wen: 1'b0, control_wen: 1'b0,
		run: 1'b1, reset_flag: 1'b0};

	typedef struct packed {
		logic              wr;
		wdt_addr_t         addr;
		logic [DATA_W-1:0] wdata;
	} wdt_apb_req_s;

	typedef enum logic {
		WDT_COUNTING,
		WDT_RESETTING
	} wdt_state_e;

endpackage : wdt_pkg

/* File: rtl/wdt_pin_sync.sv */
// Three-flop synchroniser with agreement filter and edge pulses.
// Assumes the pin is asynchronous to core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module wdt_pin_sync #(
	parameter logic RST_LEVEL = 1'b0
) (
	input  wire logic core_clk_i,
	input  wire logic rstn_i,
	input  wire logic pin_i,
	output var  logic level_o,
	output var  logic rise_o,
	output var  logic fall_o
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic agree;

	// Level only moves once the second and third stage agree
	assign agree = (s2_ff == s3_ff);

	// Sync chain, first stage feeds only the second
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_ff   <= RST_LEVEL;
			s2_ff   <= RST_LEVEL;
			s3_ff   <= RST_LEVEL;
			level_o <= RST_LEVEL;
			rise_o  <= 1'b0;
			fall_o  <= 1'b0;
		end else begin
			s1_ff   <= pin_i;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			level_o <= agree ? s3_ff : level_o;
			rise_o  <= agree & s3_ff & ~level_o;
			fall_o  <= agree & ~s3_ff & level_o;
		end
	end

endmodule : wdt_pin_sync
`default_nettype wire

/* File: rtl/wdt_prescaler.sv */
// Free-running prescaler with one tick per power-of-two tap.
// Assumes the caller holds clear_i while the counter must not run.
`timescale 1ns/10ps
`default_nettype none
module wdt_prescaler #(
	parameter int unsigned PRE_W    = wdt_pkg::PRE_W,
	parameter int unsigned TAP_BASE = wdt_pkg::TAP_BASE,
	parameter int unsigned NUM_TAPS = wdt_pkg::NUM_TAPS,
	parameter int unsigned TAP_W    = wdt_pkg::TAP_W
) (
	input  wire logic             core_clk_i,
	input  wire logic             rstn_i,
	input  wire logic             clear_i,
	input  wire logic [TAP_W-1:0] sel_i,
	output var  logic             tick_o
);

	logic [PRE_W-1:0]    cnt_ff;
	logic [NUM_TAPS-1:0] taps;

	// Tap k fires once every 2**(TAP_BASE+k) clocks
	for (genvar k = 0; k < NUM_TAPS; k++) begin : g_tap
		assign taps[k] = &cnt_ff[TAP_BASE+k-1:0];
	end

	// Tick is registered so the counter sees a clean one-cycle pulse
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_ff <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt_ff <= clear_i ? '0 : cnt_ff + PRE_W'(1);
			tick_o <= ~clear_i & taps[sel_i];
		end
	end

endmodule : wdt_prescaler
`default_nettype wire

/* File: rtl/wdt_timer.sv */
// 8-bit watchdog timer with guarded control bits and an APB port.
// Assumes an APB3 master on core_clk_i; oscillator and reset pin are
// asynchronous pins and are synchronised here.
//
// Functional notes
// - Eight-bit up-counter, readable and writable by software.
// - Rollover from FF to 00 raises internal reset and sets reset flag.
// - Reset loads the counter with zero.
// - Upper four clock-select bits read as one whatever is written.
// - Codes 1000..1110 pick system clock over 64..4096; field resets to ones.
// - Top bit zero selects dedicated oscillator; low bits ignored.
// - Counting starts by itself once reset is released.
// - Overflow reset pulse lasts 256 dedicated oscillator cycles.
// - Counting resumes from a written value, giving 1 to 256 periods.
// - Counter writes need counter-write-enable; that bit needs its guard zero.
// - Control enable needs guard zero; run and flag need enable and guard.
// - Counter advances only while run is one; run resets to one.
// - Flag clears on reset pin or guarded write of zero, never set by software.
`timescale 1ns/10ps
`default_nettype none
module wdt_timer #(
	parameter int unsigned CNT_W   = wdt_pkg::CNT_W,
	parameter int unsigned PULSE_W = wdt_pkg::PULSE_W
) (
	input  wire logic                       core_clk_i,
	input  wire logic                       rstn_i,
	// APB slave
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [wdt_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic [wdt_pkg::DATA_W-1:0] pwdata_i,
	output var  logic [wdt_pkg::DATA_W-1:0] prdata_o,
	output var  logic                       pready_o,
	output var  logic                       pslverr_o,
	// Pins
	input  wire logic                       dedicated_osc_clock_i,
	input  wire logic                       external_reset_pin_n_i,
	// Outputs to the system
	output var  logic                       wdt_reset_o,
	output var  logic                       irq_o
);

	// Registers
	wdt_pkg::wdt_state_e             state_ff;
	wdt_pkg::wdt_state_e             nxt_state;
	wdt_pkg::wdt_ctrl_s              ctrl_ff;
	wdt_pkg::wdt_ctrl_s              nxt_ctrl;
	wdt_pkg::wdt_apb_req_s           req_ff;
	logic [CNT_W-1:0]                wdt_counter_ff;
	logic [CNT_W-1:0]                nxt_wdt_counter;
	logic [wdt_pkg::SEL_W-1:0]       clksel_ff;
	logic [wdt_pkg::SEL_W-1:0]       nxt_clksel;
	logic [PULSE_W-1:0]              pulse_cnt_ff;
	logic [PULSE_W-1:0]              nxt_pulse_cnt;
	logic [wdt_pkg::IRQ_W-1:0]       irq_stat_ff;
	logic [wdt_pkg::IRQ_W-1:0]       nxt_irq_stat;
	logic [wdt_pkg::IRQ_W-1:0]       irq_mask_ff;
	logic [wdt_pkg::IRQ_W-1:0]       nxt_irq_mask;
	logic [wdt_pkg::IRQ_W-1:0]       rd_stat_ff;
	logic [wdt_pkg::DATA_W-1:0]      prdata_ff;

	// Synchronised pins
	logic                            osc_level;
	logic                            osc_rise;
	logic                            pin_n_level;
	logic                            pin_fall;

	// Decode and datapath wires
	logic                            apb_setup;
	logic                            apb_access;
	logic                            hit_ctrl;
	logic                            hit_count;
	logic                            hit_clksel;
	logic                            hit_stat;
	logic                            hit_mask;
	logic                            addr_hit;
	logic                            wr_access;
	logic [7:0]                      wbyte;
	logic [7:0]                      ctrl_rd;
	logic [7:0]                      clksel_rd;
	logic [wdt_pkg::DATA_W-1:0]      rd_data;
	logic                            pin_hold;
	logic                            resetting;
	logic                            pre_tick;
	logic                            src_tick;
	logic                            count_inc;
	logic                            wr_count;
	logic                            wr_ctrl;
	logic                            wr_clksel;
	logic                            overflow;
	logic                            pulse_end;
	logic                            stat_rd_clr;
	logic [wdt_pkg::IRQ_W-1:0]       irq_events;

	// Oscillator pin; it is slow against core_clk_i, so edges are counted
	wdt_pin_sync #(
		.RST_LEVEL (1'b0)
	) u_osc_sync (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.pin_i      (dedicated_osc_clock_i),
		.level_o    (osc_level),
		.rise_o     (osc_rise),
		.fall_o     ()
	);

	// External reset pin, idle high
	wdt_pin_sync #(
		.RST_LEVEL (1'b1)
	) u_pin_sync (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.pin_i      (external_reset_pin_n_i),
		.level_o    (pin_n_level),
		.rise_o     (),
		.fall_o     (pin_fall)
	);

	// Prescaler held clear whenever the counter is parked at zero
	wdt_prescaler u_prescaler (
		.core_clk_i (core_clk_i),
		.rstn_i     (rstn_i),
		.clear_i    (pin_hold | resetting),
		.sel_i      (clksel_ff[wdt_pkg::TAP_W-1:0]),
		.tick_o     (pre_tick)
	);

	// APB phases and address decode
	assign apb_setup  = psel_i & ~penable_i;
	assign apb_access = psel_i & penable_i;
	assign hit_ctrl   = (paddr_i == wdt_pkg::OFF_CTRL);
	assign hit_count  = (paddr_i == wdt_pkg::OFF_COUNT);
	assign hit_clksel = (paddr_i == wdt_pkg::OFF_CLKSEL);
	assign hit_stat   = (paddr_i == wdt_pkg::OFF_IRQ_STAT);
	assign hit_mask   = (paddr_i == wdt_pkg::OFF_IRQ_MASK);
	assign addr_hit   = hit_ctrl | hit_count | hit_clksel | hit_stat | hit_mask;
	assign wr_access  = apb_access & pwrite_i & addr_hit;
	assign wbyte      = pwdata_i[7:0];

	// Zero wait states; unmapped addresses answer with an error
	assign pready_o  = 1'b1;
	assign pslverr_o = apb_access & ~addr_hit;
	assign prdata_o  = prdata_ff;

	// Guard bits always read one, enables and flag show their state
	assign ctrl_rd[wdt_pkg::CS_CWEN_GUARD] = 1'b1;
	assign ctrl_rd[wdt_pkg::CS_CWEN]       = ctrl_ff.counter_wen;
	assign ctrl_rd[wdt_pkg::CS_CTWE_GUARD] = 1'b1;
	assign ctrl_rd[wdt_pkg::CS_CTWE]       = ctrl_ff.control_wen;
	assign ctrl_rd[wdt_pkg::CS_RUN_GUARD]  = 1'b1;
	assign ctrl_rd[wdt_pkg::CS_RUN]        = ctrl_ff.run;
	assign ctrl_rd[wdt_pkg::CS_FLAG_GUARD] = 1'b1;
	assign ctrl_rd[wdt_pkg::CS_FLAG]       = ctrl_ff.reset_flag;

	// Reserved upper nibble is forced, not stored
	assign clksel_rd = {wdt_pkg::CLKSEL_RSVD, clksel_ff};

	// Read mux, sampled in the setup phase
	always_comb begin
		rd_data = '0;
		if (hit_ctrl) begin
			rd_data[7:0] = ctrl_rd;
		end else if (hit_count) begin
			rd_data[CNT_W-1:0] = wdt_counter_ff;
		end else if (hit_clksel) begin
			rd_data[7:0] = clksel_rd;
		end else if (hit_stat) begin
			rd_data[wdt_pkg::IRQ_W-1:0] = irq_stat_ff;
		end else if (hit_mask) begin
			rd_data[wdt_pkg::IRQ_W-1:0] = irq_mask_ff;
		end else begin
			rd_data = '0;
		end
	end

	// Counting source and events
	assign pin_hold  = ~pin_n_level;
	assign resetting = (state_ff == wdt_pkg::WDT_RESETTING);
	assign src_tick  = clksel_ff[wdt_pkg::CLKSEL_PRE] ? pre_tick : osc_rise;
	assign count_inc = ~pin_hold & ~resetting & ctrl_ff.run & src_tick;
	// Control and clock-select writes dropped while pin or pulse holds; mask writes still land
	assign wr_ctrl   = wr_access & hit_ctrl & ~pin_hold & ~resetting;
	assign wr_clksel = wr_access & hit_clksel & ~pin_hold & ~resetting;
	// Counter write blocked unless software opened it first
	assign wr_count  = wr_access & hit_count & ctrl_ff.counter_wen
		& ~pin_hold & ~resetting;
	// A software write in the same cycle takes priority over the increment
	assign overflow  = count_inc & ~wr_count
		& (wdt_counter_ff == wdt_pkg::COUNT_MAX);
	// Sync filter delays each oscillator edge
	assign pulse_end = resetting & osc_rise
		& (pulse_cnt_ff == wdt_pkg::PULSE_OSC_CYC - wdt_pkg::PULSE_ONE);

	// Read-to-clear only drops bits that the read actually returned
	assign stat_rd_clr = apb_access & ~pwrite_i & req_ff.addr == wdt_pkg::OFF_IRQ_STAT
		& hit_stat;
	assign irq_events[wdt_pkg::IRQ_OVF]       = overflow;
	assign irq_events[wdt_pkg::IRQ_PULSE_END] = pulse_end;
	assign irq_events[wdt_pkg::IRQ_PIN_RST]   = pin_fall;

	// Sticky status, new events win over a clear in the same cycle
	assign nxt_irq_stat = (irq_stat_ff & ~(stat_rd_clr ? rd_stat_ff : wdt_pkg::IRQ_RST))
		| irq_events;
	// Mask is plain read-write
	assign nxt_irq_mask = (wr_access & hit_mask) ? pwdata_i[wdt_pkg::IRQ_W-1:0]
		: irq_mask_ff;
	assign irq_o = |(irq_stat_ff & irq_mask_ff);

	// Counter next value
	always_comb begin
		nxt_wdt_counter = wdt_counter_ff;
		if (pin_hold | resetting) begin
			nxt_wdt_counter = wdt_pkg::COUNT_RST;
		end else if (wr_count) begin
			nxt_wdt_counter = wbyte;
		end else if (count_inc) begin
			nxt_wdt_counter = wdt_counter_ff + wdt_pkg::COUNT_ONE;
		end
	end

	// Clock select; the reset pin and the end of a pulse restore ones
	always_comb begin
		nxt_clksel = clksel_ff;
		if (pin_hold | pulse_end) begin
			nxt_clksel = wdt_pkg::CLKSEL_RST;
		end else if (wr_clksel) begin
			nxt_clksel = wbyte[wdt_pkg::SEL_W-1:0];
		end
	end

	// Guarded control bits; run and flag use the enable as it stood
	// before this write, so opening and using it needs two accesses
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (pin_hold) begin
			nxt_ctrl = wdt_pkg::CTRL_RST;
		end else if (pulse_end) begin
			nxt_ctrl = wdt_pkg::CTRL_RST;
			nxt_ctrl.reset_flag = ctrl_ff.reset_flag;
		end else if (wr_ctrl) begin
			if (!wbyte[wdt_pkg::CS_CWEN_GUARD]) begin
				nxt_ctrl.counter_wen = wbyte[wdt_pkg::CS_CWEN];
			end
			if (!wbyte[wdt_pkg::CS_CTWE_GUARD]) begin
				nxt_ctrl.control_wen = wbyte[wdt_pkg::CS_CTWE];
			end
			if (ctrl_ff.control_wen && !wbyte[wdt_pkg::CS_RUN_GUARD]) begin
				nxt_ctrl.run = wbyte[wdt_pkg::CS_RUN];
			end
			// Only a zero is accepted; writing one leaves the flag alone
			if (ctrl_ff.control_wen && !wbyte[wdt_pkg::CS_FLAG_GUARD]
				&& !wbyte[wdt_pkg::CS_FLAG]) begin
				nxt_ctrl.reset_flag = 1'b0;
			end
		end
		// Hardware set beats a simultaneous software clear
		if (overflow) begin
			nxt_ctrl.reset_flag = 1'b1;
		end
	end

	// Reset pulse sequencer, timed on oscillator edges
	always_comb begin
		nxt_state     = state_ff;
		nxt_pulse_cnt = pulse_cnt_ff;
		case (state_ff)
			wdt_pkg::WDT_COUNTING: begin
				nxt_pulse_cnt = wdt_pkg::PULSE_ZERO;
				if (overflow) begin
					nxt_state = wdt_pkg::WDT_RESETTING;
				end
			end
			wdt_pkg::WDT_RESETTING: begin
				if (pin_hold) begin
					nxt_state     = wdt_pkg::WDT_COUNTING;
					nxt_pulse_cnt = wdt_pkg::PULSE_ZERO;
				end else if (pulse_end) begin
					nxt_state     = wdt_pkg::WDT_COUNTING;
					nxt_pulse_cnt = wdt_pkg::PULSE_ZERO;
				end else if (osc_rise) begin
					nxt_pulse_cnt = pulse_cnt_ff + wdt_pkg::PULSE_ONE;
				end
			end
			default: begin
				nxt_state     = wdt_pkg::WDT_COUNTING;
				nxt_pulse_cnt = wdt_pkg::PULSE_ZERO;
			end
		endcase
	end

	// Reset output comes straight from the state flop
	assign wdt_reset_o = resetting;

	// Watchdog state flops
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_ff       <= wdt_pkg::WDT_COUNTING;
			pulse_cnt_ff   <= wdt_pkg::PULSE_ZERO;
			wdt_counter_ff <= wdt_pkg::COUNT_RST;
			clksel_ff      <= wdt_pkg::CLKSEL_RST;
			ctrl_ff        <= wdt_pkg::CTRL_RST;
		end else begin
			state_ff       <= nxt_state;
			pulse_cnt_ff   <= nxt_pulse_cnt;
			wdt_counter_ff <= nxt_wdt_counter;
			clksel_ff      <= nxt_clksel;
			ctrl_ff        <= nxt_ctrl;
		end
	end

	// Interrupt flops
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_stat_ff <= wdt_pkg::IRQ_RST;
			irq_mask_ff <= wdt_pkg::IRQ_RST;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_mask_ff <= nxt_irq_mask;
		end
	end

	// Bus capture in setup; read data stays put through the access phase
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			req_ff     <= '0;
			prdata_ff  <= '0;
			rd_stat_ff <= wdt_pkg::IRQ_RST;
		end else if (apb_setup) begin
			req_ff     <= '{wr: pwrite_i, addr: paddr_i, wdata: pwdata_i};
			prdata_ff  <= rd_data;
			rd_stat_ff <= irq_stat_ff;
		end
	end

endmodule : wdt_timer
`default_nettype wire

/* File: sim/wdt_timer_monitor.sv */
// Port-level concurrent checks for the watchdog timer.
// Assumes it is bound to wdt_timer and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module wdt_timer_monitor (
	input wire logic                       core_clk_i,
	input wire logic                       rstn_i,
	input wire logic                       psel_i,
	input wire logic                       penable_i,
	input wire logic                       pwrite_i,
	input wire logic [wdt_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [wdt_pkg::DATA_W-1:0] pwdata_i,
	input wire logic [wdt_pkg::DATA_W-1:0] prdata_o,
	input wire logic                       pready_o,
	input wire logic                       pslverr_o,
	input wire logic                       dedicated_osc_clock_i,
	input wire logic                       external_reset_pin_n_i,
	input wire logic                       wdt_reset_o,
	input wire logic                       irq_o
);
	logic       mapped;
	logic       setup_rd;
	logic       osc_q_ff;
	logic [9:0] osc_cnt_ff;
	logic [3:0] pin_hi_ff;

	// Decode as software sees it
	assign mapped   = paddr_i inside {wdt_pkg::OFF_CTRL, wdt_pkg::OFF_COUNT, wdt_pkg::OFF_CLKSEL,
		wdt_pkg::OFF_IRQ_STAT, wdt_pkg::OFF_IRQ_MASK};
	assign setup_rd = psel_i && !penable_i && !pwrite_i;

	// Oscillator edges inside a pulse; pin quiet time, since the pin cuts a pulse short
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			osc_q_ff   <= 1'b0;
			osc_cnt_ff <= 10'h000;
			pin_hi_ff  <= 4'h0;
		end else begin
			osc_q_ff   <= dedicated_osc_clock_i;
			osc_cnt_ff <= !wdt_reset_o ? 10'h000 :
				osc_cnt_ff + {9'h000, dedicated_osc_clock_i && !osc_q_ff};
			pin_hi_ff  <= !external_reset_pin_n_i ? 4'h0 :
				(pin_hi_ff == 4'hF) ? pin_hi_ff : pin_hi_ff + 4'h1;
		end
	end

	default clocking mon_cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	chk_ready_always: assert property (pready_o)
		else $error("pready low");
	chk_unmapped_err: assert property (psel_i && penable_i |-> pslverr_o == !mapped)
		else $error("slave error does not match decode");
	chk_rdata_upper: assert property (setup_rd |=> prdata_o[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	chk_clksel_ones: assert property (
		setup_rd && paddr_i == wdt_pkg::OFF_CLKSEL |=> prdata_o[7:4] == 4'hF)
		else $error("clock select upper bits not one");
	chk_guard_bits_one: assert property (
		setup_rd && paddr_i == wdt_pkg::OFF_CTRL
		|=> prdata_o[7] && prdata_o[5] && prdata_o[3] && prdata_o[1])
		else $error("guard bit read zero");
	chk_pin_clears_flag: assert property (
		!external_reset_pin_n_i [*8] ##0 setup_rd && paddr_i == wdt_pkg::OFF_CTRL |=> !prdata_o[0])
		else $error("flag set while pin held");
	chk_pin_zero_count: assert property (
		!external_reset_pin_n_i [*8] ##0 setup_rd && paddr_i == wdt_pkg::OFF_COUNT
		|=> prdata_o[7:0] == 8'h00)
		else $error("counter not zero while pin held");
	chk_pulse_not_long: assert property (wdt_reset_o |-> osc_cnt_ff <= 10'h102)
		else $error("reset pulse too long");
	chk_pulse_not_short: assert property (
		$fell(wdt_reset_o) && pin_hi_ff == 4'hF |-> osc_cnt_ff >= 10'h0FE)
		else $error("reset pulse too short");
	chk_mask_zero_quiet: assert property (
		psel_i && penable_i && pwrite_i && paddr_i == wdt_pkg::OFF_IRQ_MASK && pwdata_i[2:0] == 3'h0
		|=> !irq_o)
		else $error("interrupt with all sources masked");

	cov_pulse: cover property ($rose(wdt_reset_o));
	cov_irq: cover property ($rose(irq_o));
	cov_err: cover property (pslverr_o);
endmodule : wdt_timer_monitor

bind wdt_timer wdt_timer_monitor wdt_timer_monitor_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.dedicated_osc_clock_i(dedicated_osc_clock_i), .external_reset_pin_n_i(external_reset_pin_n_i),
	.wdt_reset_o(wdt_reset_o), .irq_o(irq_o));
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the watchdog timer, driven over APB.
// Assumes wdt_timer with its bound checker; the bench drives every port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic               core_clk_i;
	logic               rstn_i;
	logic               psel;
	logic               penable;
	logic               pwrite;
	wdt_pkg::wdt_addr_t paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               osc = 1'b0;
	logic               pin_n;
	logic               wdt_rst;
	logic               irq;
	logic [2:0]         osc_div = 3'h0;
	logic [31:0]        rd;
	logic               err;
	int                 osc_rises = 0;
	int                 r0;
	int                 n_fail;
	int                 n_compared;

	wdt_timer wdt_timer_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .dedicated_osc_clock_i(osc),
		.external_reset_pin_n_i(pin_n), .wdt_reset_o(wdt_rst), .irq_o(irq));

	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	// Oscillator pin of ten core cycles, stepped on the core edge
	always @(posedge core_clk_i) begin
		osc_div <= (osc_div == 3'h4) ? 3'h0 : osc_div + 3'h1;
		if (osc_div == 3'h4) begin
			osc <= ~osc;
			osc_rises <= osc_rises + {31'h0000_0000, ~osc};
		end
	end

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	// One APB transfer; request held until pready is seen high
	task automatic apb(input wdt_pkg::wdt_addr_t a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : apb

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic chk_rng(input string name, input int lo, input int hi, input logic [31:0] got);
		n_compared++;
		if (^got === 1'bx || got < lo || got > hi) begin
			n_fail++;
			$display("[ERR] %s expected %0d..%0d seen %h", name, lo, hi, got);
		end
	endtask : chk_rng

	task automatic rdc(input wdt_pkg::wdt_addr_t a, input logic [31:0] exp, input string name);
		apb(a, 1'b0, 32'h0000_0000);
		chk(name, exp, rd);
	endtask : rdc

	// Bounded wait for the internal reset output to reach a level
	task automatic wait_rst(input logic lvl, input int lim);
		int n;
		n = 0;
		while (wdt_rst !== lvl && n < lim) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= lim) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : wait_rst

	initial begin
		repeat (100000) @(posedge core_clk_i);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		rstn_i = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pin_n = 1'b1;
		n_fail = 0;
		n_compared = 0;
		repeat (4) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		// Reset values, unmapped word, self-start of counting
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00AE, "ctrl reset");
		rdc(wdt_pkg::OFF_COUNT, 32'h0000_0000, "count reset");
		rdc(wdt_pkg::OFF_CLKSEL, 32'h0000_00FF, "clksel reset");
		rdc(wdt_pkg::OFF_IRQ_MASK, 32'h0000_0000, "mask reset");
		rdc(12'h014, 32'h0000_0000, "unmapped read");
		chk("unmapped err", 32'h0000_0001, {31'h0000_0000, err});
		repeat (8400) @(posedge core_clk_i);
		rdc(wdt_pkg::OFF_COUNT, 32'h0000_0001, "count self start");
		$display("test reset done");
		// Guarded writes, refused and accepted
		apb(wdt_pkg::OFF_COUNT, 1'b1, 32'h0000_0055);
		rdc(wdt_pkg::OFF_COUNT, 32'h0000_0001, "count write refused");
		apb(wdt_pkg::OFF_CLKSEL, 1'b1, 32'h0000_0000);
		rdc(wdt_pkg::OFF_CLKSEL, 32'h0000_00F0, "clksel upper ones");
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_00FD);
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00AE, "ctrl locked");
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_00DF);
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00BE, "ctrl unlocked");
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_00FD);
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00BE, "flag not set");
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_00F3);
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00BA, "run stopped");
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_007F);
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00FA, "count wen");
		apb(wdt_pkg::OFF_COUNT, 1'b1, 32'h0000_00C3);
		repeat (100) @(posedge core_clk_i);
		rdc(wdt_pkg::OFF_COUNT, 32'h0000_00C3, "count held");
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_00F7);
		$display("test guards done");
		// Prescaled rates 64..4096, then the oscillator with low bits set
		for (int k = 0; k < 7; k++) begin
			apb(wdt_pkg::OFF_CLKSEL, 1'b1, 32'h0000_0008 + k);
			apb(wdt_pkg::OFF_COUNT, 1'b1, 32'h0000_0000);
			repeat (3 << (6 + k)) @(posedge core_clk_i);
			apb(wdt_pkg::OFF_COUNT, 1'b0, 32'h0000_0000);
			chk_rng("prescaled count", 3, 4, rd);
		end
		apb(wdt_pkg::OFF_CLKSEL, 1'b1, 32'h0000_0005);
		apb(wdt_pkg::OFF_COUNT, 1'b1, 32'h0000_0000);
		r0 = osc_rises;
		repeat (200) @(posedge core_clk_i);
		apb(wdt_pkg::OFF_COUNT, 1'b0, 32'h0000_0000);
		chk_rng("osc count", osc_rises - r0 - 2, osc_rises - r0 + 1, rd);
		$display("test rates done");
		// Overflow, pulse, interrupt masking and clearing
		apb(wdt_pkg::OFF_CLKSEL, 1'b1, 32'h0000_0008);
		apb(wdt_pkg::OFF_COUNT, 1'b1, 32'h0000_00FD);
		wait_rst(1'b1, 1000);
		r0 = osc_rises;
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
		apb(wdt_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0001);
		@(posedge core_clk_i);
		chk("irq raised", 32'h0000_0001, {31'h0000_0000, irq});
		rdc(wdt_pkg::OFF_IRQ_STAT, 32'h0000_0001, "stat overflow");
		@(posedge core_clk_i);
		chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
		apb(wdt_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0007);
		wait_rst(1'b0, 4000);
		chk_rng("pulse osc edges", 255, 257, osc_rises - r0);
		repeat (2) @(posedge core_clk_i);
		chk("irq pulse end", 32'h0000_0001, {31'h0000_0000, irq});
		rdc(wdt_pkg::OFF_IRQ_STAT, 32'h0000_0002, "stat pulse end");
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00AF, "ctrl after pulse");
		rdc(wdt_pkg::OFF_CLKSEL, 32'h0000_00FF, "clksel after pulse");
		rdc(wdt_pkg::OFF_COUNT, 32'h0000_0000, "count after pulse");
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_00FC);
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00AF, "flag clear refused");
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_00DF);
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_00FC);
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00BE, "flag cleared");
		$display("test overflow done");
		// External pin cuts a pulse and holds defaults
		apb(wdt_pkg::OFF_CTRL, 1'b1, 32'h0000_007F);
		apb(wdt_pkg::OFF_COUNT, 1'b1, 32'h0000_00FF);
		wait_rst(1'b1, 9000);
		pin_n <= 1'b0;
		repeat (10) @(posedge core_clk_i);
		rdc(wdt_pkg::OFF_COUNT, 32'h0000_0000, "count pin held");
		rdc(wdt_pkg::OFF_CTRL, 32'h0000_00AE, "ctrl pin held");
		pin_n <= 1'b1;
		repeat (10) @(posedge core_clk_i);
		apb(wdt_pkg::OFF_IRQ_MASK, 1'b1, 32'h0000_0000);
		rdc(wdt_pkg::OFF_IRQ_STAT, 32'h0000_0005, "stat pin");
		$display("test pin done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
